// file: restart_and_config_access.v
`timescale 1ns/10ps
`include "restart_cfg_regs.vh"

// Overview of operation
// RULE_01 - Writing 0x00 to the restart register triggers a full device reset with rail re-sequencing.
// RULE_02 - The reset is issued 50 us after the write so the bus acknowledge can finish.
// RULE_03 - Writing 0xC0 turns off every rail and general purpose output, each after its configured delay.
// RULE_04 - After the commanded shutdown the device does not reset and resumes monitoring.
// RULE_05 - The configuration address is high register bits 15:8 joined to low register bits 7:0.
// RULE_06 - The configuration data word is high register bits 15:8 and low register bits 7:0, for writes and reads.
// RULE_07 - A two-byte write starting at the low address register loads low then high address byte.
// RULE_08 - A two-byte write starting at the low data register loads low then high data byte.
// RULE_09 - After the address is set the stored word appears low byte in low data, high byte in high data.
// RULE_10 - While held in reset with the log-present flag set, error registers read the nonvolatile log.
// RULE_11 - A 48-byte read of memory starting at 0x1000 returns the whole nonvolatile log.
// RULE_12 - The log-present flag is set at reset when the log holds entries and cleared only by a reset finding it empty.
// RULE_13 - An empty error log reads back as all zeros.
// RULE_14 - Any other restart value causes neither reset nor shutdown.
module restart_and_config_access #(
   parameter RESTART_WAIT_CYCLES = `RESTART_WAIT_CYCLES,
   parameter MS_CYCLES = `MS_CYCLES
) (
   // clock and reset
   input wire core_clk,
   input wire sys_rst,
   // host register port, byte by byte from the bus front end
   input wire busAddrLoad,
   input wire [7:0] busAddr,
   input wire busWrStb,
   input wire [7:0] busWrData,
   input wire busRdStb,
   output reg [7:0] busRdData,
   // configuration memory
   output reg cfgMemWrStb,
   output reg cfgMemRdStb,
   output reg [15:0] cfgMemAddr,
   output reg [15:0] cfgMemWrData,
   input wire cfgMemRdValid,
   input wire [15:0] cfgMemRdData,
   // error logs
   input wire [47:0] sramLogEntry,
   input wire sramLogEmpty,
   input wire [47:0] nvLogEntry,
   input wire nvLogEmpty,
   // pins from outside the clock domain
   input wire holdInResetPin,
   input wire nvLogHasEntriesPin,
   // shutdown delays in ms, one byte per output
   input wire [`OUT_COUNT*`SHUT_DELAY_WIDTH-1:0] shutDelayMs,
   // device control
   output reg deviceRestart,
   output wire [`OUT_COUNT-1:0] forceOff,
   output reg monitorPaused,
   output reg nonvolatile_log_present
);

   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_WAIT = 2'b01;
   localparam [1:0] ST_SHUT = 2'b10;
   localparam [16:0] RESTART_LAST = RESTART_WAIT_CYCLES[16:0] - 17'h00001;
   localparam [16:0] MS_LAST = MS_CYCLES[16:0] - 17'h00001;

   reg [7:0] ptr;
   reg [7:0] cfg_addr_low;
   reg [7:0] cfg_addr_high;
   reg [7:0] cfg_data_low;
   reg [7:0] cfg_data_high;
   reg [1:0] state;
   reg [16:0] waitCount;
   reg [16:0] msCount;
   reg [7:0] shutElapsed;
   reg holdMeta, holdSync, nvMeta, nvSync;
   reg [1:0] settleCount;
   reg [7:0] next_ptr;
   reg [7:0] readValue;
   wire [7:0] logByte;
   wire [7:0] curPtr;
   wire [15:0] cfgAddr;
   wire [15:0] logEnd;
   wire [2:0] errIndex;
   wire inLogWindow;
   wire allOff;

   // a new transfer restarts the pointer, later bytes auto-increment only within the error set and the 16-bit pairs
   assign curPtr = busAddrLoad ? busAddr : ptr;
   // RULE_05 address assembly
   assign cfgAddr = {cfg_addr_high, cfg_addr_low};
   assign logEnd = `NV_LOG_BASE + `NV_LOG_BYTES;
   assign inLogWindow = (cfgAddr >= `NV_LOG_BASE) && (cfgAddr < logEnd);
   assign errIndex = curPtr[2:0];

   // 16-bit pairs wrap back on themselves, the error set wraps after six
   always @* begin
      case (curPtr)
         `REG_ERROR_LAST: next_ptr = `REG_ERROR_FIRST;
         // RULE_07 address pair increment
         `REG_CFG_ADDR_LOW: next_ptr = `REG_CFG_ADDR_HIGH;
         `REG_CFG_ADDR_HIGH: next_ptr = `REG_CFG_ADDR_LOW;
         // RULE_08 data pair increment
         `REG_CFG_DATA_LOW: next_ptr = `REG_CFG_DATA_HIGH;
         `REG_CFG_DATA_HIGH: next_ptr = `REG_CFG_DATA_LOW;
         default: begin
            if (curPtr >= `REG_ERROR_FIRST && curPtr < `REG_ERROR_LAST) begin
               next_ptr = curPtr + 8'h01;
            end else begin
               next_ptr = curPtr;
            end
         end
      endcase
   end

   error_log_select logSel (
      .holdInReset(holdSync),
      .nvLogPresent(nonvolatile_log_present),
      .sramLogEntry(sramLogEntry),
      .sramLogEmpty(sramLogEmpty),
      .nvLogEntry(nvLogEntry),
      .nvLogEmpty(nvLogEmpty),
      .byteIndex(errIndex),
      .logByte(logByte)
   );

   always @* begin
      case (curPtr)
         `REG_CFG_ADDR_LOW: readValue = cfg_addr_low;
         `REG_CFG_ADDR_HIGH: readValue = cfg_addr_high;
         // RULE_06 data halves on read
         `REG_CFG_DATA_LOW: readValue = cfg_data_low;
         `REG_CFG_DATA_HIGH: readValue = cfg_data_high;
         default: begin
            if (curPtr >= `REG_ERROR_FIRST && curPtr <= `REG_ERROR_LAST) begin
               readValue = logByte;
            end else begin
               readValue = `READ_IDLE_VALUE;
            end
         end
      endcase
   end

   // pin synchronisers
   always @(posedge core_clk) begin
      if (sys_rst) begin
         holdMeta <= 1'b0;
         holdSync <= 1'b0;
         nvMeta <= 1'b0;
         nvSync <= 1'b0;
      end else begin
         holdMeta <= holdInResetPin;
         holdSync <= holdMeta;
         nvMeta <= nvLogHasEntriesPin;
         nvSync <= nvMeta;
      end
   end

   // flag survives reset; only the capture after a reset or while held in reset may change it
   always @(posedge core_clk) begin
      if (sys_rst) begin
         settleCount <= 2'h0;
      end else if (settleCount != `SYNC_SETTLE_CYCLES) begin
         settleCount <= settleCount + 2'h1;
      end
   end

   always @(posedge core_clk) begin
      // RULE_12 capture log presence
      if (!sys_rst && (holdSync || settleCount == 2'h2)) begin
         nonvolatile_log_present <= nvSync;
      end
   end

   // register bus and configuration memory
   always @(posedge core_clk) begin
      if (sys_rst) begin
         ptr <= 8'h00;
         busRdData <= `READ_IDLE_VALUE;
         {cfg_addr_high, cfg_addr_low} <= `CFG_ADDR_RESET;
         {cfg_data_high, cfg_data_low} <= `CFG_DATA_RESET;
         cfgMemWrStb <= 1'b0;
         cfgMemRdStb <= 1'b0;
         cfgMemAddr <= `CFG_ADDR_RESET;
         cfgMemWrData <= `CFG_DATA_RESET;
      end else begin
         cfgMemWrStb <= 1'b0;
         cfgMemRdStb <= 1'b0;
         if (busAddrLoad && !busWrStb && !busRdStb) begin
            ptr <= busAddr;
         end
         if (busWrStb) begin
            ptr <= next_ptr;
            case (curPtr)
               `REG_CFG_ADDR_LOW: cfg_addr_low <= busWrData;
               `REG_CFG_ADDR_HIGH: begin
                  cfg_addr_high <= busWrData;
                  // RULE_09 fetch word once address complete
                  cfgMemRdStb <= 1'b1;
                  cfgMemAddr <= {busWrData, cfg_addr_low};
               end
               `REG_CFG_DATA_LOW: cfg_data_low <= busWrData;
               `REG_CFG_DATA_HIGH: begin
                  // RULE_06 full word written
                  cfg_data_high <= busWrData;
                  cfgMemWrStb <= 1'b1;
                  cfgMemAddr <= cfgAddr;
                  cfgMemWrData <= {busWrData, cfg_data_low};
               end
               default: begin
               end
            endcase
         end else if (busRdStb) begin
            ptr <= next_ptr;
            busRdData <= readValue;
            // RULE_11 stream log words on high byte read
            if (curPtr == `REG_CFG_DATA_HIGH && inLogWindow) begin
               {cfg_addr_high, cfg_addr_low} <= cfgAddr + `CFG_WORD_STEP;
               cfgMemRdStb <= 1'b1;
               cfgMemAddr <= cfgAddr + `CFG_WORD_STEP;
            end
         end
         // RULE_09 returned word into data halves
         if (cfgMemRdValid) begin
            cfg_data_low <= cfgMemRdData[7:0];
            cfg_data_high <= cfgMemRdData[15:8];
         end
      end
   end

   // restart and shutdown sequencing
   always @(posedge core_clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         waitCount <= 17'h00000;
         msCount <= 17'h00000;
         shutElapsed <= 8'h00;
         deviceRestart <= 1'b0;
         monitorPaused <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (busWrStb && curPtr == `REG_RESTART_COMMAND) begin
                  // RULE_01 reset command
                  if (busWrData == `CMD_FULL_RESET) begin
                     state <= ST_WAIT;
                     waitCount <= 17'h00000;
                  // RULE_03 shutdown command
                  end else if (busWrData == `CMD_SHUTDOWN) begin
                     state <= ST_SHUT;
                     msCount <= 17'h00000;
                     shutElapsed <= 8'h00;
                     monitorPaused <= 1'b1;
                  end
                  // RULE_14 other codes ignored
               end
            end
            ST_WAIT: begin
               // RULE_02 hold off so the acknowledge completes
               if (waitCount == RESTART_LAST) begin
                  deviceRestart <= 1'b1;
               end else begin
                  waitCount <= waitCount + 17'h00001;
               end
            end
            ST_SHUT: begin
               if (msCount == MS_LAST) begin
                  msCount <= 17'h00000;
                  if (shutElapsed != 8'hFF) begin
                     shutElapsed <= shutElapsed + 8'h01;
                  end
               end else begin
                  msCount <= msCount + 17'h00001;
               end
               // RULE_04 back to monitoring, no reset
               if (allOff) begin
                  state <= ST_IDLE;
                  monitorPaused <= 1'b0;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // outputs stay off after shutdown until the next device reset
   genvar ch;
   generate
      for (ch = 0; ch < `OUT_COUNT; ch = ch + 1) begin : offChan
         reg offFlag;
         wire [7:0] delay;
         assign delay = shutDelayMs[ch*`SHUT_DELAY_WIDTH +: `SHUT_DELAY_WIDTH];
         always @(posedge core_clk) begin
            if (sys_rst) begin
               offFlag <= 1'b0;
            // RULE_03 per-output delay
            end else if (state == ST_SHUT && shutElapsed >= delay) begin
               offFlag <= 1'b1;
            end
         end
         assign forceOff[ch] = offFlag;
      end
   endgenerate

   assign allOff = &forceOff;

endmodule // restart_and_config_access

// file: restart_cfg_regs.vh
`ifndef RESTART_CFG_REGS_VH
`define RESTART_CFG_REGS_VH

// register offsets on the host register port
`define REG_ERROR_FIRST 8'h20
`define REG_ERROR_LAST 8'h25
`define REG_RESTART_COMMAND 8'h2F
`define REG_CFG_ADDR_LOW 8'h30
`define REG_CFG_ADDR_HIGH 8'h31
`define REG_CFG_DATA_LOW 8'h32
`define REG_CFG_DATA_HIGH 8'h33

// restart command codes
`define CMD_FULL_RESET 8'h00
`define CMD_SHUTDOWN 8'hC0

// reset values
`define CFG_ADDR_RESET 16'h0000
`define CFG_DATA_RESET 16'h0000
`define READ_IDLE_VALUE 8'h00

// nonvolatile error log window in configuration memory
`define NV_LOG_BASE 16'h1000
`define NV_LOG_BYTES 16'h0030
`define CFG_WORD_STEP 16'h0002
`define ERROR_ENTRY_BYTES 6

// shutdown outputs: rails 7:0, general purpose outputs 11:8
`define OUT_COUNT 12
`define SHUT_DELAY_WIDTH 8

// timing
`define CLK_PERIOD_NS 10
`define RESTART_WAIT_US 50
`define RESTART_WAIT_CYCLES ((`RESTART_WAIT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MS_TIME_US 1000
`define MS_CYCLES ((`MS_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_SETTLE_CYCLES 2'h3

`endif

// file: error_log_select.v
`timescale 1ns/10ps
`include "restart_cfg_regs.vh"

module error_log_select (
   // source selection
   input wire holdInReset,
   input wire nvLogPresent,
   // log heads
   input wire [47:0] sramLogEntry,
   input wire sramLogEmpty,
   input wire [47:0] nvLogEntry,
   input wire nvLogEmpty,
   // byte select
   input wire [2:0] byteIndex,
   output reg [7:0] logByte
);

   reg [47:0] entry;
   reg empty;

   always @* begin
      // RULE_10 flash log in reset
      if (holdInReset && nvLogPresent) begin
         entry = nvLogEntry;
         empty = nvLogEmpty;
      end else begin
         entry = sramLogEntry;
         empty = sramLogEmpty;
      end
      // RULE_13 empty reads zero
      if (empty || byteIndex >= `ERROR_ENTRY_BYTES) begin
         logByte = 8'h00;
      end else begin
         logByte = entry[byteIndex * 8 +: 8];
      end
   end

endmodule // error_log_select

// file: restart_and_config_access_properties.sv
`timescale 1ns/10ps
`include "restart_cfg_regs.vh"
module restart_and_config_access_properties #(
   parameter RESTART_WAIT_CYCLES = 20,
   parameter MS_CYCLES = 10
) (
   // clock and reset
   input wire core_clk,
   input wire sys_rst,
   // host register port
   input wire busAddrLoad,
   input wire [7:0] busAddr,
   input wire busWrStb,
   input wire [7:0] busWrData,
   input wire busRdStb,
   input wire [7:0] busRdData,
   // configuration memory
   input wire cfgMemWrStb,
   input wire cfgMemRdStb,
   input wire [15:0] cfgMemAddr,
   input wire [15:0] cfgMemWrData,
   input wire cfgMemRdValid,
   input wire [15:0] cfgMemRdData,
   // device control
   input wire deviceRestart,
   input wire [`OUT_COUNT-1:0] forceOff,
   input wire monitorPaused
);
   // commands are only judged when the pointer is loaded with them
   wire cmdWr = busWrStb && busAddrLoad && busAddr == 8'h2F;
   wire idle = !deviceRestart && !monitorPaused && forceOff == 0;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   chk_restart_delay: assert property (
      $rose(deviceRestart) |->
      $past(cmdWr && busWrData == 8'h00, RESTART_WAIT_CYCLES + 1))
      else $error("restart raised at the wrong time");
   chk_restart_early: assert property (
      cmdWr && busWrData == 8'h00 && idle |=> !deviceRestart [*8])
      else $error("restart raised too early");
   chk_shut_start: assert property (
      cmdWr && busWrData == 8'hC0 && idle |=> monitorPaused && !deviceRestart)
      else $error("shutdown did not start");
   chk_other_code: assert property (
      cmdWr && busWrData != 8'h00 && busWrData != 8'hC0 && idle |=> idle)
      else $error("other restart code acted");
   chk_shut_done: assert property (
      $fell(monitorPaused) |-> (&forceOff) && !deviceRestart)
      else $error("shutdown ended wrongly");
   chk_off_hold: assert property (
      (forceOff & $past(forceOff)) == $past(forceOff))
      else $error("output turned back on");
   chk_addr_pair: assert property (
      (busWrStb && busAddrLoad && busAddr == 8'h30) ##1
      (busWrStb && !busAddrLoad) |=> cfgMemRdStb &&
      cfgMemAddr == {$past(busWrData), $past(busWrData, 2)})
      else $error("address pair wrong");
   chk_data_pair: assert property (
      (busWrStb && busAddrLoad && busAddr == 8'h32) ##1
      (busWrStb && !busAddrLoad) |=> cfgMemWrStb &&
      cfgMemWrData == {$past(busWrData), $past(busWrData, 2)})
      else $error("data pair wrong");
   chk_read_low: assert property (
      cfgMemRdValid ##1 (busRdStb && busAddrLoad && busAddr == 8'h32) |=>
      busRdData == $past(cfgMemRdData[7:0], 2))
      else $error("read low byte wrong");
endmodule // restart_and_config_access_properties

bind restart_and_config_access restart_and_config_access_properties #(
   .RESTART_WAIT_CYCLES(RESTART_WAIT_CYCLES), .MS_CYCLES(MS_CYCLES)
) chk (.core_clk, .sys_rst, .busAddrLoad, .busAddr, .busWrStb, .busWrData,
   .busRdStb, .busRdData, .cfgMemWrStb, .cfgMemRdStb, .cfgMemAddr,
   .cfgMemWrData, .cfgMemRdValid, .cfgMemRdData, .deviceRestart, .forceOff,
   .monitorPaused);

// file: cfg_mem_model.sv
`timescale 1ns/10ps
module cfg_mem_model (
   // clock and pacing
   input wire core_clk,
   input wire slow,
   // memory port
   input wire cfgMemWrStb,
   input wire cfgMemRdStb,
   input wire [15:0] cfgMemAddr,
   input wire [15:0] cfgMemWrData,
   output reg cfgMemRdValid,
   output reg [15:0] cfgMemRdData
);
   reg [15:0] mem [0:65535];
   reg [15:0] word;
   reg [2:0] lag;
   integer i;
   initial begin
      for (i = 0; i < 65536; i = i + 1) begin
         mem[i] = i[15:0] ^ 16'h5AC3;
      end
      cfgMemRdValid = 1'b0;
      cfgMemRdData = 16'h0000;
      word = 16'h0000;
      lag = 3'h0;
   end
   always @(posedge core_clk) begin
      cfgMemRdValid <= 1'b0;
      // data is only good with valid, so it toggles otherwise
      cfgMemRdData <= ~cfgMemRdData;
      if (cfgMemWrStb) begin
         mem[cfgMemAddr] <= cfgMemWrData;
      end
      if (cfgMemRdStb) begin
         word <= mem[cfgMemAddr];
         lag <= slow ? 3'h4 : 3'h1;
      end else if (lag == 3'h1) begin
         cfgMemRdValid <= 1'b1;
         cfgMemRdData <= word;
         lag <= 3'h0;
      end else if (lag != 3'h0) begin
         lag <= lag - 3'h1;
      end
   end
endmodule // cfg_mem_model

// file: restart_and_config_access_tb.sv
`timescale 1ns/10ps
module restart_and_config_access_tb;
   reg core_clk, sys_rst, busAddrLoad, busWrStb, busRdStb, slow;
   reg [7:0] busAddr, busWrData;
   reg sramLogEmpty, nvLogEmpty, holdInResetPin, nvLogHasEntriesPin;
   reg [47:0] sramLogEntry, nvLogEntry;
   reg [95:0] shutDelayMs;
   reg [15:0] w;
   wire [7:0] busRdData;
   wire cfgMemWrStb, cfgMemRdStb, cfgMemRdValid, deviceRestart;
   wire monitorPaused, nonvolatile_log_present;
   wire [15:0] cfgMemAddr, cfgMemWrData, cfgMemRdData;
   wire [11:0] forceOff;
   integer fail_count, cmp_count, i, n;
   localparam RW = 20;
   restart_and_config_access #(.RESTART_WAIT_CYCLES(RW), .MS_CYCLES(10)) dut (
      .core_clk, .sys_rst, .busAddrLoad, .busAddr, .busWrStb, .busWrData,
      .busRdStb, .busRdData, .cfgMemWrStb, .cfgMemRdStb, .cfgMemAddr,
      .cfgMemWrData, .cfgMemRdValid, .cfgMemRdData, .sramLogEntry,
      .sramLogEmpty, .nvLogEntry, .nvLogEmpty, .holdInResetPin,
      .nvLogHasEntriesPin, .shutDelayMs, .deviceRestart, .forceOff,
      .monitorPaused, .nonvolatile_log_present);
   cfg_mem_model mem (.core_clk, .slow, .cfgMemWrStb, .cfgMemRdStb,
      .cfgMemAddr, .cfgMemWrData, .cfgMemRdValid, .cfgMemRdData);
   task finish_test;
      begin
         $display("compares %0d mismatches %0d", cmp_count, fail_count);
         if (fail_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
         end else begin
            $display("TB: FAIL");
         end
         $finish;
      end
   endtask
   task cmpv(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task cyc(input wr, input rd, input ld, input [7:0] a, input [7:0] d);
      begin
         busWrStb = wr;
         busRdStb = rd;
         busAddrLoad = ld;
         busAddr = a;
         busWrData = d;
         @(posedge core_clk);
         #1;
      end
   endtask
   task tick(input integer lim);
      begin
         cyc(0, 0, 0, 8'h00, 8'h00);
         n = n + 1;
         if (n > lim) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED %0t wait ran out", $time);
            finish_test;
         end
      end
   endtask
   task rdc(input ld, input [7:0] a, input [7:0] e);
      begin
         cyc(0, 1, ld, a, 8'h00);
         cmpv(busRdData, e);
      end
   endtask
   // one idle edge after valid lets the data registers load
   task waitv;
      begin
         n = 0;
         while (cfgMemRdValid !== 1'b1) begin
            tick(50);
         end
         tick(60);
      end
   endtask
   task rst;
      begin
         sys_rst = 1;
         repeat (3) @(posedge core_clk);
         #1;
         sys_rst = 0;
         repeat (4) cyc(0, 0, 0, 8'h00, 8'h00);
      end
   endtask
   // seven reads also cover the wrap from the last byte to the first
   task logrd(input [47:0] e);
      for (i = 0; i < 7; i = i + 1) begin
         rdc(i == 0, 8'h20, e[8 * (i % 6) +: 8]);
      end
   endtask
   task setaddr(input [7:0] lo, input [7:0] hi);
      begin
         cyc(1, 0, 1, 8'h30, lo);
         cyc(1, 0, 0, 8'h00, hi);
         cmpv(cfgMemAddr, {hi, lo});
         waitv;
      end
   endtask
   task t_log;
      begin
         cmpv(nonvolatile_log_present, 1);
         logrd(nvLogEntry);
         holdInResetPin = 0;
         repeat (4) cyc(0, 0, 0, 8'h00, 8'h00);
         logrd(sramLogEntry);
         sramLogEmpty = 1;
         logrd(48'h0);
         nvLogHasEntriesPin = 0;
         repeat (4) cyc(0, 0, 0, 8'h00, 8'h00);
         cmpv(nonvolatile_log_present, 1);
         rst;
         cmpv(nonvolatile_log_present, 0);
         $display("log test done");
      end
   endtask
   task t_cfg;
      begin
         setaddr(8'h34, 8'h12);
         rdc(1, 8'h32, 8'hF7);
         cyc(1, 0, 1, 8'h32, 8'hEF);
         cyc(1, 0, 0, 8'h00, 8'hBE);
         cmpv({cfgMemWrStb, cfgMemWrData}, 17'h1BEEF);
         setaddr(8'h34, 8'h12);
         rdc(1, 8'h32, 8'hEF);
         rdc(0, 8'h00, 8'hBE);
         rdc(0, 8'h00, 8'hEF);
         rdc(1, 8'h2F, 8'h00);
         rdc(1, 8'h40, 8'h00);
         $display("config test done");
      end
   endtask
   task t_stream;
      begin
         slow = 1;
         setaddr(8'h00, 8'h10);
         for (i = 0; i < 24; i = i + 1) begin
            w = (16'h1000 + 2 * i) ^ 16'h5AC3;
            rdc(1, 8'h32, w[7:0]);
            rdc(0, 8'h00, w[15:8]);
            if (i < 23) waitv;
         end
         slow = 0;
         $display("stream test done");
      end
   endtask
   task t_other;
      begin
         for (i = 0; i < 5; i = i + 1) begin
            cyc(1, 0, 1, 8'h2F, (i == 4) ? 8'hC1 : 8'h01 << i);
            repeat (30) cyc(0, 0, 0, 8'h00, 8'h00);
            cmpv({deviceRestart, monitorPaused, forceOff}, 0);
         end
         $display("other code test done");
      end
   endtask
   task t_shut;
      begin
         cyc(1, 0, 1, 8'h2F, 8'hC0);
         n = 0;
         while (forceOff[0] !== 1'b1) begin
            tick(10);
         end
         // zero delay: output goes off at the first edge after the write
         cmpv(n, 1);
         n = 0;
         while (forceOff !== 12'hFFF) begin
            // delays rise with channel, so outputs go off in order
            cmpv(forceOff & (forceOff + 12'h001), 0);
            tick(200);
         end
         n = 0;
         while (monitorPaused !== 1'b0) begin
            tick(5);
         end
         repeat (40) cyc(0, 0, 0, 8'h00, 8'h00);
         cmpv({deviceRestart, forceOff}, 16'h0FFF);
         rst;
         $display("shutdown test done");
      end
   endtask
   task t_restart;
      begin
         cyc(1, 0, 1, 8'h2F, 8'h00);
         n = 0;
         while (deviceRestart !== 1'b1) begin
            tick(100);
         end
         // wait counter runs RW edges after the write edge
         cmpv(n, RW);
         rst;
         $display("restart test done");
      end
   endtask
   initial begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      fail_count = 0;
      cmp_count = 0;
      // reset from time zero so no edge sees an unknown reset level
      sys_rst = 1;
      slow = 0;
      sramLogEmpty = 0;
      nvLogEmpty = 0;
      holdInResetPin = 1;
      nvLogHasEntriesPin = 1;
      sramLogEntry = 48'h1122_3344_5566;
      nvLogEntry = 48'hA1B2_C3D4_E5F6;
      for (i = 0; i < 12; i = i + 1) begin
         shutDelayMs[8 * i +: 8] = i;
      end
      shutDelayMs[95:88] = 8'h0B;
      cyc(0, 0, 0, 8'h00, 8'h00);
      rst;
      t_log;
      t_cfg;
      t_stream;
      t_other;
      t_shut;
      t_restart;
      finish_test;
   end
endmodule // restart_and_config_access_tb
